/* File: pwm_sync_dma_duty_update.sv */
// Behaviour
// - duty values arrive only from dma port
// - unlock applies period and dead-time at boundary
// - without unlock, shadows stay unapplied
// - unlock holds until applied, then clears
// - after count plus one periods, apply duty
// - write ready set when ready, status read clears
// - request optionally waits for selected compare match
// - transfer done set when all duties received
// - buffer empty set when dma has nothing pending
`timescale 1ns/1ps
`default_nettype none
module pwm_sync_dma_duty_update
    import pwm_sync_pkg::*;
#(
    parameter int N = NUM_CH
) (
    input  wire logic                clk,
    input  wire logic                rstn,
    input  wire logic [N-1:0]        sync_channel_mode_reg,
    input  wire logic                period_end,
    input  wire logic [NUM_CMP-1:0]  compare_match,
    input  wire logic [1:0]          dma_trigger_mode,
    input  wire logic [CMP_W-1:0]    dma_trigger_compare_select,
    input  wire logic                shadow_write,
    input  wire logic [N-1:0]        shadow_channel_sel,
    input  wire timing_type          shadow_timing,
    input  wire logic                update_period_write,
    input  wire logic [UPD_W-1:0]    sync_update_period_shadow,
    input  wire logic                update_unlock_write,
    input  wire logic                dma_valid,
    input  wire logic [DUTY_W-1:0]   dma_data,
    input  wire logic                dma_pending,
    input  wire logic                second_irq_status_read,
    output logic                     dma_request,
    output logic                     update_unlock,
    output logic [UPD_W-1:0]         update_period_count,
    output logic [UPD_W-1:0]         period_counter,
    output dma_status_type           status,
    output logic [N*DUTY_W-1:0]      duty_active,
    output logic [N*PERIOD_W-1:0]    period_active,
    output logic [N*DT_W-1:0]        dead_active
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // next synchronous channel at or above a start index
    function automatic logic [7:0] next_sync(input logic [N-1:0] mask,
                                             input logic [7:0]   from);
        logic [7:0] res;
        res = 8'hFF;
        for (int i = N - 1; i >= 0; i--) begin
            if (mask[i] && (8'(i) >= from)) begin
                res = 8'(i);
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    timing_type          shadow [N];
    timing_type          next_shadow [N];
    logic [DUTY_W-1:0]   duty_pending [N];
    logic [DUTY_W-1:0]   next_duty_pending [N];
    logic [UPD_W-1:0]    upd_pending;
    logic [UPD_W-1:0]    next_upd_pending;
    logic [N*DUTY_W-1:0]   next_duty_active;
    logic [N*PERIOD_W-1:0] next_period_active;
    logic [N*DT_W-1:0]     next_dead_active;
    logic                next_update_unlock;
    logic [UPD_W-1:0]    next_update_period_count;
    logic [UPD_W-1:0]    next_period_counter;
    fetch_state_type     state;
    fetch_state_type     next_state;
    logic [7:0]          ch_idx;
    logic [7:0]          next_ch_idx;
    logic                next_dma_request;
    dma_status_type      next_status;
    logic                trig_ok;
    logic                auto_update;
    logic                fetch_done;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb begin
        for (int i = 0; i < N; i++) begin
            next_shadow[i]       = shadow[i];
            next_duty_pending[i] = duty_pending[i];
        end
        next_upd_pending         = upd_pending;
        next_duty_active         = duty_active;
        next_period_active       = period_active;
        next_dead_active         = dead_active;
        next_update_unlock       = update_unlock;
        next_update_period_count = update_period_count;
        next_period_counter      = period_counter;
        next_state               = state;
        next_ch_idx              = ch_idx;
        next_dma_request         = 1'b0;
        next_status              = status;
        fetch_done               = 1'b0;

        // trigger may wait for a chosen comparison unit
        trig_ok = (dma_trigger_mode == TRIG_ON_CMP)
                  ? compare_match[dma_trigger_compare_select] : 1'b1;

        // shadows are written by software only
        if (shadow_write) begin
            for (int i = 0; i < N; i++) begin
                if (shadow_channel_sel[i]) begin
                    next_shadow[i] = shadow_timing;
                end
            end
        end
        if (update_period_write) begin
            next_upd_pending = sync_update_period_shadow;
        end

        // unlock stays set until a boundary consumes it
        if (update_unlock_write) begin
            next_update_unlock = 1'b1;
        end
        if (period_end && update_unlock) begin
            for (int i = 0; i < N; i++) begin
                if (sync_channel_mode_reg[i]) begin
                    next_period_active[i*PERIOD_W +: PERIOD_W] = shadow[i].period;
                    next_dead_active[i*DT_W +: DT_W]           = shadow[i].dead_time;
                end
            end
            next_update_unlock = update_unlock_write;
        end

        // update-period counter runs on sync period boundaries
        auto_update = period_end && (period_counter == update_period_count);
        if (period_end) begin
            next_period_counter = auto_update ? '0 : UPD_W'(period_counter + 1'b1);
        end
        if (auto_update) begin
            for (int i = 0; i < N; i++) begin
                if (sync_channel_mode_reg[i]) begin
                    next_duty_active[i*DUTY_W +: DUTY_W] = duty_pending[i];
                end
            end
            next_update_period_count = upd_pending;
        end

        // dma fetch of duty values, one per sync channel
        case (state)
            ST_IDLE: begin
                next_ch_idx = next_sync(sync_channel_mode_reg, 8'h00);
                if (trig_ok && (next_ch_idx != 8'hFF)) begin
                    next_state                  = ST_FETCH;
                    next_status.write_ready_flag = 1'b1;
                end
            end
            ST_FETCH: begin
                next_dma_request = !dma_valid;
                if (dma_valid && (ch_idx < 8'(N))) begin
                    next_duty_pending[ch_idx[$clog2(N)-1:0]] = dma_data;
                    next_ch_idx = next_sync(sync_channel_mode_reg, 8'(ch_idx + 8'h01));
                    if (next_ch_idx == 8'hFF) begin
                        fetch_done       = 1'b1;
                        next_dma_request = 1'b0;
                        next_state       = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // fetch again once the new values are in use
                if (auto_update) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase

        // read clears ready; a new set in the same cycle wins
        if (second_irq_status_read) begin
            next_status.write_ready_flag       = 1'b0;
            next_status.dma_transfer_done_flag = 1'b0;
        end
        if (state == ST_IDLE && next_state == ST_FETCH) begin
            next_status.write_ready_flag = 1'b1;
        end
        if (fetch_done) begin
            next_status.dma_transfer_done_flag = 1'b1;
        end
        next_status.dma_buffer_empty_flag = !dma_pending;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) begin
                shadow[i]       <= '{period: RST_PERIOD, dead_time: RST_DEAD};
                duty_pending[i] <= RST_DUTY;
            end
            upd_pending         <= RST_UPD;
            duty_active         <= {N{RST_DUTY}};
            period_active       <= {N{RST_PERIOD}};
            dead_active         <= {N{RST_DEAD}};
            update_unlock       <= 1'b0;
            update_period_count <= RST_UPD;
            period_counter      <= '0;
            state               <= ST_IDLE;
            ch_idx              <= 8'h00;
            dma_request         <= 1'b0;
            status              <= '{1'b0, 1'b0, 1'b1};
        end else begin
            for (int i = 0; i < N; i++) begin
                shadow[i]       <= next_shadow[i];
                duty_pending[i] <= next_duty_pending[i];
            end
            upd_pending         <= next_upd_pending;
            duty_active         <= next_duty_active;
            period_active       <= next_period_active;
            dead_active         <= next_dead_active;
            update_unlock       <= next_update_unlock;
            update_period_count <= next_update_period_count;
            period_counter      <= next_period_counter;
            state               <= next_state;
            ch_idx              <= next_ch_idx;
            dma_request         <= next_dma_request;
            status              <= next_status;
        end
    end

endmodule
`default_nettype wire

/* File: pwm_sync_pkg.sv */
package pwm_sync_pkg;

    localparam int          NUM_CH         = 4;
    localparam int          DUTY_W         = 16;
    localparam int          PERIOD_W       = 16;
    localparam int          DT_W           = 16;
    localparam int          UPD_W          = 4;
    localparam int          CMP_W          = 3;
    localparam int          NUM_CMP        = 8;
    localparam int          CNT_W          = 16;

    localparam logic [15:0] RST_PERIOD     = 16'hFFFF;
    localparam logic [15:0] RST_DUTY       = 16'h0000;
    localparam logic [15:0] RST_DEAD       = 16'h0000;
    localparam logic [3:0]  RST_UPD        = 4'h0;

    // trigger modes of the dma request
    localparam logic [1:0]  TRIG_NONE      = 2'h0;
    localparam logic [1:0]  TRIG_ON_CMP    = 2'h1;

    // channel settings carried together
    typedef struct packed {
        logic [PERIOD_W-1:0] period;
        logic [DT_W-1:0]     dead_time;
    } timing_type;

    // status flags as seen by software
    typedef struct packed {
        logic write_ready_flag;
        logic dma_transfer_done_flag;
        logic dma_buffer_empty_flag;
    } dma_status_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_FETCH  = 2'b01,
        ST_WAIT   = 2'b11
    } fetch_state_type;

endpackage

/* File: pwm_sync_dma_duty_update_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_sync_dma_duty_update_properties
    import pwm_sync_pkg::*;
#(
    parameter int N = NUM_CH
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  period_end,
    input wire logic [NUM_CMP-1:0]    compare_match,
    input wire logic [1:0]            dma_trigger_mode,
    input wire logic [CMP_W-1:0]      dma_trigger_compare_select,
    input wire logic                  update_unlock_write,
    input wire logic                  second_irq_status_read,
    input wire logic                  update_unlock,
    input wire logic [UPD_W-1:0]      update_period_count,
    input wire logic [UPD_W-1:0]      period_counter,
    input wire dma_status_type        status,
    input wire logic [N*DUTY_W-1:0]   duty_active,
    input wire logic [N*PERIOD_W-1:0] period_active,
    input wire logic [N*DT_W-1:0]     dead_active
);
    // one clock domain, so one default clock and reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // selected match as one signal, so its past value is a plain sample
    logic sel_match;
    assign sel_match = compare_match[dma_trigger_compare_select];

    a_unlock_sets: assert property (update_unlock_write |=> update_unlock)
        else $error("unlock bit did not set");
    a_unlock_holds: assert property (update_unlock && !period_end |=> update_unlock)
        else $error("unlock bit dropped before a boundary");
    a_unlock_clears: assert property
        (update_unlock && period_end && !update_unlock_write |=> !update_unlock)
        else $error("unlock bit stayed after its update");
    a_timing_locked: assert property
        (!(update_unlock && period_end) |=> $stable(period_active) && $stable(dead_active))
        else $error("period or dead time changed while locked");
    a_duty_locked: assert property
        (!(period_end && period_counter == update_period_count) |=> $stable(duty_active))
        else $error("duty changed outside an update boundary");
    a_count_reload: assert property
        (period_end && period_counter == update_period_count |=> period_counter == 4'h0)
        else $error("period counter not restarted after update");
    a_done_holds: assert property
        (status.dma_transfer_done_flag && !second_irq_status_read
            |=> status.dma_transfer_done_flag)
        else $error("transfer done flag lost without a read");
    a_ready_holds: assert property
        (status.write_ready_flag && !second_irq_status_read |=> status.write_ready_flag)
        else $error("write ready flag lost without a read");
    a_trig_wait: assert property
        ($rose(status.write_ready_flag) && $past(dma_trigger_mode) == TRIG_ON_CMP
            |-> $past(sel_match))
        else $error("write ready rose without the selected match");
endmodule
bind pwm_sync_dma_duty_update pwm_sync_dma_duty_update_properties #(.N(N)) i_props (.*);
`default_nettype wire

/* File: pwm_dma_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pwm_dma_model
    import pwm_sync_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              dma_request,
    input  wire logic [3:0]        lag,
    input  wire logic [DUTY_W-1:0] base,
    input  wire logic [DUTY_W-1:0] total,
    output logic                   dma_valid,
    output logic [DUTY_W-1:0]      dma_data,
    output logic                   dma_pending
);
    logic [3:0]        wait_cnt;
    logic [DUTY_W-1:0] seq;

    // queue order is channel order; lag makes the answer slow
    always @(posedge clk) begin
        if (!rstn) begin
            dma_valid <= 1'b0;
            dma_data  <= 16'h0000;
            wait_cnt  <= 4'h0;
            seq       <= 16'h0000;
        end else if (dma_request && !dma_valid && dma_pending && wait_cnt >= lag) begin
            dma_valid <= 1'b1;
            dma_data  <= base + seq;
            seq       <= seq + 16'h0001;
            wait_cnt  <= 4'h0;
        end else begin
            // released bus toggles so a stale word never looks valid
            dma_valid <= 1'b0;
            dma_data  <= ~dma_data;
            wait_cnt  <= (dma_request && wait_cnt != 4'hF) ? wait_cnt + 4'h1 : wait_cnt;
        end
    end
    assign dma_pending = (seq != total);
endmodule
`default_nettype wire

/* File: pwm_sync_dma_duty_update_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module pwm_sync_dma_duty_update_bench
    import pwm_sync_pkg::*;
;
    logic           clk, rstn, period_end, shadow_write, update_period_write, dma_request;
    logic           update_unlock_write, second_irq_status_read, dma_valid, dma_pending;
    logic           update_unlock;
    logic [1:0]     dma_trigger_mode;
    logic [2:0]     dma_trigger_compare_select;
    logic [3:0]     sync_channel_mode_reg, shadow_channel_sel, sync_update_period_shadow, lag;
    logic [3:0]     update_period_count, period_counter;
    logic [5:0]     strb;
    logic [7:0]     compare_match;
    logic [15:0]    dma_data, base, total;
    logic [63:0]    duty_active, period_active, dead_active;
    timing_type     shadow_timing;
    dma_status_type status;
    int             n_errors, samples_checked;

    // strobe bits: 0 boundary, 1 shadow, 2 period count, 3 unlock, 4 read, 5 match
    assign {second_irq_status_read, update_unlock_write, update_period_write} = strb[4:2];
    assign {shadow_write, period_end} = strb[1:0];
    assign compare_match = {2'h0, strb[5], 5'h00};
    always #10 clk = ~clk;
    pwm_sync_dma_duty_update i_dut (.*);
    pwm_dma_model i_dma (.*);
    ////////////////////////////////////////////////////////////////////////////////
    // one-cycle strobe, result looked at on the following falling edge
    task automatic pulse(input int k);
        @(posedge clk);
        strb <= 6'(1 << k);
        @(posedge clk);
        strb <= 6'h00;
        @(negedge clk);
    endtask
    // bounded wait on a status bit; running out ends the run
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        while (status[b] !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (status[b] !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask
    task automatic results();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // first batch, read-clear, then first automatic update
    task automatic t_fetch();
        wait_flag(1);
        `check(status, 3'h7)
        pulse(4);
        `check(status, 3'h1)
        pulse(0);
        `check(duty_active, {16'h1002, 16'h0000, 16'h1001, 16'h1000})
    endtask
    // new count loads at an update, then count plus one boundaries pass
    task automatic t_period();
        @(posedge clk);
        sync_update_period_shadow <= 4'h2;
        total <= 16'h0006;
        pulse(2);
        `check(dma_request, 1'b1)
        wait_flag(1);
        `check(status[2], 1'b1)
        pulse(4);
        pulse(0);
        `check(update_period_count, 4'h2)
        @(posedge clk);
        total <= 16'h0009;
        dma_trigger_mode <= TRIG_ON_CMP;
        dma_trigger_compare_select <= 3'h5;
        wait_flag(1);
        pulse(4);
        pulse(0);
        pulse(0);
        `check(duty_active, {16'h1005, 16'h0000, 16'h1004, 16'h1003})
        pulse(0);
        `check(duty_active, {16'h1008, 16'h0000, 16'h1007, 16'h1006})
    endtask
    // fetch held back until the selected comparison matches
    task automatic t_trigger();
        @(posedge clk);
        total <= 16'h000C;
        repeat (8) @(negedge clk);
        `check({status[2], dma_request}, 2'h0)
        pulse(5);
        wait_flag(2);
        wait_flag(1);
    endtask
    // shadow timing stays locked until unlock meets a boundary
    task automatic t_unlock();
        @(posedge clk);
        shadow_channel_sel <= 4'h3;
        shadow_timing <= {16'h0123, 16'h0045};
        pulse(1);
        pulse(0);
        `check(period_active, {4{16'hFFFF}})
        `check(period_counter, 4'h1)
        pulse(3);
        repeat (3) @(negedge clk);
        `check(update_unlock, 1'b1)
        pulse(0);
        `check(period_active, {32'hFFFFFFFF, 32'h01230123})
        `check(dead_active, {32'h00000000, 32'h00450045})
        `check(update_unlock, 1'b0)
    endtask
    initial begin
        {clk, rstn, strb, dma_trigger_mode, dma_trigger_compare_select} = '0;
        {shadow_channel_sel, sync_update_period_shadow, shadow_timing} = '0;
        {n_errors, samples_checked} = '0;
        {sync_channel_mode_reg, lag, base, total} = {4'hB, 4'h2, 16'h1000, 16'h0003};
        repeat (10) @(negedge clk);
        `check({period_active, update_unlock, status}, {{4{16'hFFFF}}, 4'h1})
        @(posedge clk);
        rstn <= 1'b1;
        t_fetch();
        t_period();
        t_trigger();
        t_unlock();
        results();
    end
endmodule
`default_nettype wire
